// ### shared/sar_adc_defs.svh
// Register offsets, field positions, reset values, widths and response codes
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

`define ADDR_MAIN_CONTROL   32'hFFFF_0500
`define ADDR_POS_SELECT     32'hFFFF_0504
`define ADDR_NEG_SELECT     32'hFFFF_0508
`define ADDR_STATUS         32'hFFFF_050C
`define ADDR_RESULT         32'hFFFF_0510
`define ADDR_IF_RESET       32'hFFFF_0514
`define ADDR_GAIN_TRIM      32'hFFFF_0530
`define ADDR_OFFSET_TRIM    32'hFFFF_0534

`define RST_MAIN_CONTROL    8'h00
`define RST_POS_SELECT      8'h00
`define RST_NEG_SELECT      8'h01
`define RST_TRIM            10'h200
`define RST_RESULT          12'h000

`define CTL_START_EN        7
`define CTL_BUSY_PIN_EN     6
`define CTL_POWER           5
`define CTL_MODE_HI         4
`define CTL_MODE_LO         3
`define CTL_TYPE_HI         2
`define CTL_TYPE_LO         0

`define TYPE_PIN            3'h0
`define TYPE_SINGLE_SW      3'h3
`define TYPE_CONT_SW        3'h4

`define SEL_W               5
`define RESULT_W            12
`define TRIM_W              10
`define TRIM_SHIFT          9
`define TRIM_MID            11'sh200
`define RESULT_MAX          15'sh0FFF
`define SAR_MSB             12'h800

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### shared/sar_adc_pkg.sv
// Types shared by the converter interface
package sar_adc_pkg;

    typedef enum logic [2:0] {
        ST_ACQUIRE = 3'b000,
        ST_OPEN    = 3'b001,
        ST_SWAP    = 3'b010,
        ST_CONVERT = 3'b011,
        ST_DONE    = 3'b100
    } sar_state_t;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_DIFF   = 2'b01,
        MODE_PSEUDO = 2'b10,
        MODE_RSVD   = 2'b11
    } input_mode_t;

endpackage

// ### src/sar_adc_interface.sv
// Converter register interface and successive-approximation sequencer
`include "sar_adc_defs.svh"

// Contract
// - Positive select: low five bits, top zero
// - Positive codes route external inputs 0-10, 12
// - Positive codes pick DACs, sensor, ground, ref
// - Negative select: low five bits, top zero
// - Negative codes valid set differs, others reserved
// - Ready bit 0 set at end, raises irq
// - Reading result clears the ready flag
// - Active pin high through whole conversion
// - Active pin shown only when enabled
// - Result read-only, twelve bits, resets zero
// - Any write to reset restores all defaults
// - Gain trim ten bits, resets 0x200
// - Offset trim ten bits, resets 0x200
// - Differential, pseudo-differential, single-ended modes
// - Inputs disconnected while stepping to balance
// - Open balancing switch before moving inputs
// - Single-ended: negative switch tied to ground
// - Control bit 6 enables active pin
// - Single software type returns to zero
module sar_adc_interface (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        conv_start_pin,
    input  wire logic        comparator_high,
    output logic [11:0]      dac_trial_code,
    output logic             balancing_switch_closed,
    output logic             positive_input_switch_b,
    output logic             negative_input_switch_b,
    output logic             negative_tied_ground,
    output logic [4:0]       positive_mux_code,
    output logic             positive_code_valid,
    output logic [4:0]       negative_mux_code,
    output logic             negative_code_valid,
    output logic             conversion_active_pin,
    output logic             port0_bit0_pin,
    output logic             converter_irq
);

    logic [7:0]              ctl_reg;
    logic [4:0]              pos_sel_reg;
    logic [4:0]              neg_sel_reg;
    logic                    ready_reg;
    logic [11:0]             result_reg;
    logic [9:0]              gain_reg;
    logic [9:0]              offset_reg;
    sar_adc_pkg::sar_state_t state_reg;
    sar_adc_pkg::sar_state_t state_next;
    logic [11:0]             sar_reg;
    logic [11:0]             mask_reg;
    logic                    aw_hold_reg;
    logic                    w_hold_reg;
    logic [31:0]             awaddr_reg;
    logic [31:0]             wdata_reg;
    logic [3:0]              wstrb_reg;
    logic                    wr_fire;
    logic                    rd_fire;
    logic                    soft_reset;
    logic                    result_read;
    logic                    conv_done;
    logic                    trigger;
    logic [2:0]              conv_type;
    logic                    single_end;
    logic [31:0]             rd_word;
    logic                    rd_hit;
    logic                    wr_hit;
    logic signed [14:0]      scaled;
    logic signed [14:0]      corrected;
    logic [11:0]             trimmed;

    assign conv_type  = ctl_reg[`CTL_TYPE_HI:`CTL_TYPE_LO];
    assign single_end = ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO]
                        == sar_adc_pkg::MODE_SINGLE;
    assign wr_fire    = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign rd_fire    = s_axi_arvalid && s_axi_arready;
    assign soft_reset = wr_fire && awaddr_reg == `ADDR_IF_RESET;
    assign result_read = rd_fire && s_axi_araddr == `ADDR_RESULT;
    assign conv_done  = state_reg == sar_adc_pkg::ST_DONE;

    // Start request from the selected trigger source
    always_comb
    begin
        trigger = 1'b0;
        if (ctl_reg[`CTL_START_EN] && ctl_reg[`CTL_POWER])
        begin
            trigger = conv_type == `TYPE_SINGLE_SW ||
                      conv_type == `TYPE_CONT_SW ||
                      (conv_type == `TYPE_PIN && conv_start_pin);
        end
    end

    // Write channel capture, address and data in either order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 32'h0000_0000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_hold_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;  // Lanes kept with the data
            end
            else if (wr_fire)
                w_hold_reg <= 1'b0;
        end
    end

    // Write ready and response handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read decode; reserved bits read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `ADDR_MAIN_CONTROL: rd_word[7:0] = ctl_reg;
            `ADDR_POS_SELECT:   rd_word[4:0] = pos_sel_reg;
            `ADDR_NEG_SELECT:   rd_word[4:0] = neg_sel_reg;
            `ADDR_STATUS:       rd_word[0]   = ready_reg;
            `ADDR_RESULT:       rd_word[11:0] = result_reg;
            `ADDR_IF_RESET:     rd_word = 32'h0000_0000;
            `ADDR_GAIN_TRIM:    rd_word[9:0] = gain_reg;
            `ADDR_OFFSET_TRIM:  rd_word[9:0] = offset_reg;
            default:            rd_hit = 1'b0;
        endcase
    end

    // Write decode; status and result accept but ignore data
    always_comb
    begin
        unique case (awaddr_reg)
            `ADDR_MAIN_CONTROL, `ADDR_POS_SELECT, `ADDR_NEG_SELECT,
            `ADDR_STATUS, `ADDR_RESULT, `ADDR_IF_RESET,
            `ADDR_GAIN_TRIM, `ADDR_OFFSET_TRIM: wr_hit = 1'b1;
            default:                            wr_hit = 1'b0;
        endcase
    end

    // Read channel, answer one cycle after the address
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Main control; a write to other registers never blocks the type clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_reg <= `RST_MAIN_CONTROL;
        else if (soft_reset)
            ctl_reg <= `RST_MAIN_CONTROL;
        else if (wr_fire && wstrb_reg[0] &&
                 awaddr_reg == `ADDR_MAIN_CONTROL)
            ctl_reg <= wdata_reg[7:0];
        else if (conv_done && conv_type == `TYPE_SINGLE_SW)
            ctl_reg[`CTL_TYPE_HI:`CTL_TYPE_LO] <= 3'h0;
    end

    // Selectors and trims; any interface reset write restores defaults
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_sel_reg <= 5'(`RST_POS_SELECT);
            neg_sel_reg <= 5'(`RST_NEG_SELECT);
            gain_reg    <= `RST_TRIM;
            offset_reg  <= `RST_TRIM;
        end
        else if (soft_reset)
        begin
            pos_sel_reg <= 5'(`RST_POS_SELECT);
            neg_sel_reg <= 5'(`RST_NEG_SELECT);
            gain_reg    <= `RST_TRIM;
            offset_reg  <= `RST_TRIM;
        end
        else if (wr_fire && wstrb_reg[0])
        begin
            unique case (awaddr_reg)
                `ADDR_POS_SELECT:   pos_sel_reg <= wdata_reg[4:0];
                `ADDR_NEG_SELECT:   neg_sel_reg <= wdata_reg[4:0];
                `ADDR_GAIN_TRIM:
                    if (wstrb_reg[1])
                        gain_reg <= wdata_reg[9:0];
                `ADDR_OFFSET_TRIM:
                    if (wstrb_reg[1])
                        offset_reg <= wdata_reg[9:0];
                default: ;
            endcase
        end
    end

    // Sequencer state: acquire, open, swap, convert, done
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            sar_adc_pkg::ST_ACQUIRE:
                if (trigger)
                    state_next = sar_adc_pkg::ST_OPEN;
            sar_adc_pkg::ST_OPEN:    state_next = sar_adc_pkg::ST_SWAP;
            sar_adc_pkg::ST_SWAP:    state_next = sar_adc_pkg::ST_CONVERT;
            sar_adc_pkg::ST_CONVERT:
                if (mask_reg[0])
                    state_next = sar_adc_pkg::ST_DONE;
            sar_adc_pkg::ST_DONE:    state_next = sar_adc_pkg::ST_ACQUIRE;
            default:                 state_next = sar_adc_pkg::ST_ACQUIRE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= sar_adc_pkg::ST_ACQUIRE;
        else if (soft_reset)
            state_reg <= sar_adc_pkg::ST_ACQUIRE;
        else
            state_reg <= state_next;
    end

    // Binary search on the comparator, one bit per clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sar_reg  <= 12'h000;
            mask_reg <= 12'h000;
        end
        else if (state_reg == sar_adc_pkg::ST_SWAP)
        begin
            sar_reg  <= `SAR_MSB;
            mask_reg <= `SAR_MSB;
        end
        else if (state_reg == sar_adc_pkg::ST_CONVERT)
        begin
            sar_reg  <= (comparator_high ? sar_reg : sar_reg & ~mask_reg)
                        | (mask_reg >> 1);
            mask_reg <= mask_reg >> 1;
        end
    end

    // Analog switch drive; balancing opens a cycle before inputs move
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            balancing_switch_closed <= 1'b1;
            positive_input_switch_b <= 1'b0;
            negative_input_switch_b <= 1'b0;
            negative_tied_ground    <= 1'b1;
            dac_trial_code          <= 12'h000;
        end
        else
        begin
            balancing_switch_closed <= state_next
                                       == sar_adc_pkg::ST_ACQUIRE;
            positive_input_switch_b <= state_next
                                       != sar_adc_pkg::ST_ACQUIRE &&
                                       state_next != sar_adc_pkg::ST_OPEN;
            negative_input_switch_b <= state_next
                                       != sar_adc_pkg::ST_ACQUIRE &&
                                       state_next != sar_adc_pkg::ST_OPEN;
            negative_tied_ground    <= single_end;
            dac_trial_code          <= sar_reg;
        end
    end

    // Gain and offset correction of the finished code
    always_comb
    begin
        scaled    = 15'($unsigned(22'(sar_reg) * 22'(gain_reg))
                        >> `TRIM_SHIFT);
        corrected = scaled +
                    15'(($signed({1'b0, offset_reg}) - `TRIM_MID) >>> 2);
        if (corrected < 0)
            trimmed = 12'h000;
        else if (corrected > `RESULT_MAX)
            trimmed = 12'hFFF;
        else
            trimmed = corrected[11:0];
    end

    // Result word, ready flag and interrupt; a new result beats a read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_reg    <= `RST_RESULT;
            ready_reg     <= 1'b0;
            converter_irq <= 1'b0;
        end
        else if (soft_reset)
        begin
            result_reg    <= `RST_RESULT;
            ready_reg     <= 1'b0;
            converter_irq <= 1'b0;
        end
        else
        begin
            converter_irq <= conv_done;
            if (conv_done)
            begin
                result_reg <= trimmed;
                ready_reg  <= 1'b1;
            end
            else if (result_read)
                ready_reg <= 1'b0;
        end
    end

    // Busy indication and its port pin copy
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conversion_active_pin <= 1'b0;
            port0_bit0_pin        <= 1'b0;
        end
        else
        begin
            conversion_active_pin <= state_next != sar_adc_pkg::ST_ACQUIRE
                && state_next != sar_adc_pkg::ST_DONE;
            port0_bit0_pin <= ctl_reg[`CTL_BUSY_PIN_EN] &&
                (state_next != sar_adc_pkg::ST_ACQUIRE &&
                 state_next != sar_adc_pkg::ST_DONE);
        end
    end

    // Channel codes and their legality
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            positive_mux_code   <= 5'(`RST_POS_SELECT);
            negative_mux_code   <= 5'(`RST_NEG_SELECT);
            positive_code_valid <= 1'b1;
            negative_code_valid <= 1'b1;
        end
        else
        begin
            positive_mux_code   <= pos_sel_reg;
            negative_mux_code   <= neg_sel_reg;
            positive_code_valid <= pos_sel_reg <= 5'h0A ||
                pos_sel_reg == 5'h0C ||
                (pos_sel_reg >= 5'h0E && pos_sel_reg <= 5'h13);
            negative_code_valid <= neg_sel_reg <= 5'h0A ||
                neg_sel_reg == 5'h0C ||
                (neg_sel_reg >= 5'h0F && neg_sel_reg <= 5'h12);
        end
    end

    property p_ready_on_done;
        @(posedge clk) disable iff (!rst_n)
        conv_done && !soft_reset |=> ready_reg && converter_irq;
    endproperty
    a_ready_on_done: assert property (p_ready_on_done)
        else $error("ready flag or irq missing after conversion");

    property p_read_clears;
        @(posedge clk) disable iff (!rst_n)
        result_read && !conv_done |=> !ready_reg;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("result read did not clear ready");

    property p_active_span;
        @(posedge clk) disable iff (!rst_n || soft_reset)
        $rose(conversion_active_pin) |-> conversion_active_pin[*8]
            ##1 conversion_active_pin[*6] ##1 !conversion_active_pin;
    endproperty
    a_active_span: assert property (p_active_span)
        else $error("active pin span is not fourteen cycles");

    property p_pin_gated;
        @(posedge clk) disable iff (!rst_n)
        port0_bit0_pin |-> conversion_active_pin;
    endproperty
    a_pin_gated: assert property (p_pin_gated)
        else $error("port pin high without active conversion");

    property p_soft_reset;
        @(posedge clk) disable iff (!rst_n)
        soft_reset |=> gain_reg == `RST_TRIM && offset_reg == `RST_TRIM
            && neg_sel_reg == `RST_NEG_SELECT && !ready_reg;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("interface reset left a register changed");

    property p_break_first;
        @(posedge clk) disable iff (!rst_n)
        $fell(balancing_switch_closed) |-> !positive_input_switch_b
            ##1 positive_input_switch_b;
    endproperty
    a_break_first: assert property (p_break_first)
        else $error("inputs moved before balancing switch opened");

    property p_single_clears;
        @(posedge clk) disable iff (!rst_n)
        conv_done && conv_type == `TYPE_SINGLE_SW
            && !(wr_fire && awaddr_reg == `ADDR_MAIN_CONTROL)
            |=> conv_type == 3'h0;
    endproperty
    a_single_clears: assert property (p_single_clears)
        else $error("single conversion type not returned to zero");

    property p_ro_kept;
        @(posedge clk) disable iff (!rst_n)
        wr_fire && awaddr_reg == `ADDR_RESULT && !conv_done
            |=> $stable(result_reg);
    endproperty
    a_ro_kept: assert property (p_ro_kept)
        else $error("write changed the result register");

    c_conversion: cover property (@(posedge clk) disable iff (!rst_n)
        conv_done);
    c_read_result: cover property (@(posedge clk) disable iff (!rst_n)
        result_read && ready_reg);
    c_soft_reset: cover property (@(posedge clk) disable iff (!rst_n)
        soft_reset);

endmodule // sar_adc_interface

// ### tb/tb_sar_adc_interface.sv
// Register, conversion and soft reset tests for the converter interface
`include "sar_adc_defs.svh"
module tb_sar_adc_interface;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        start, comp, awready, wready, bvalid, arready, rvalid;
    logic        tied_gnd, act, pin, irq, pval, nval, bal, psw, nsw;
    logic [11:0] dac;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [4:0]  pcode, ncode;
    int          fails, num_checks, cyc, act_cnt, pin_cnt, n0, p0;
    int          open_cnt, sw_cnt, o0, s0;
    localparam logic [4:0] CODES[6] =
        '{5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h13, 5'h14};
    localparam logic [5:0] PV = 6'b101110;
    localparam logic [5:0] NV = 6'b101000;
    sar_adc_interface u_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_start_pin(start),
        .comparator_high(comp), .dac_trial_code(dac),
        .balancing_switch_closed(bal), .positive_input_switch_b(psw),
        .negative_input_switch_b(nsw),
        .negative_tied_ground(tied_gnd), .positive_mux_code(pcode),
        .positive_code_valid(pval), .negative_mux_code(ncode),
        .negative_code_valid(nval), .conversion_active_pin(act),
        .port0_bit0_pin(pin), .converter_irq(irq));
    // Clock, 40 ns period
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Cycle watchdog and busy-time counters
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (act) act_cnt <= act_cnt + 1;
        if (pin) pin_cnt <= pin_cnt + 1;
        if (!bal) open_cnt <= open_cnt + 1;
        if (psw && nsw) sw_cnt <= sw_cnt + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rdw(input logic [31:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        rdw(a, rd, rs);
        chk(rd, exp);
        chk({30'h0, rs}, {30'h0, `RESP_OKAY});
    endtask
    task automatic defaults();
        rchk(`ADDR_MAIN_CONTROL, 32'h0000_0000);
        rchk(`ADDR_POS_SELECT, 32'h0000_0000);
        rchk(`ADDR_NEG_SELECT, 32'h0000_0001);
        rchk(`ADDR_STATUS, 32'h0000_0000);
        rchk(`ADDR_RESULT, 32'h0000_0000);
        rchk(`ADDR_GAIN_TRIM, 32'h0000_0200);
        rchk(`ADDR_OFFSET_TRIM, 32'h0000_0200);
    endtask
    initial
    begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, start} = '0;
        {awaddr, wdata, araddr} = '0;
        comp = 1'b1;
        {fails, num_checks, cyc, act_cnt, pin_cnt, open_cnt, sw_cnt} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        defaults();
        // Selector codes: masked readback and reserved-code flags
        for (int i = 0; i < 6; i++)
        begin
            wr(`ADDR_POS_SELECT, {27'h007, CODES[i]});
            wr(`ADDR_NEG_SELECT, {27'h007, CODES[i]});
            rchk(`ADDR_POS_SELECT, {27'h0, CODES[i]});
            rchk(`ADDR_NEG_SELECT, {27'h0, CODES[i]});
            chk({31'h0, pval}, {31'h0, PV[5 - i]});
            chk({31'h0, nval}, {31'h0, NV[5 - i]});
            chk({27'h0, pcode}, {27'h0, CODES[i]});
            chk({27'h0, ncode}, {27'h0, CODES[i]});
        end
        wr(`ADDR_GAIN_TRIM, 32'h0000_03FF);
        rchk(`ADDR_GAIN_TRIM, 32'h0000_03FF);
        wr(`ADDR_GAIN_TRIM, 32'h0000_0200);
        wr(`ADDR_OFFSET_TRIM, 32'h0000_FFFF);
        rchk(`ADDR_OFFSET_TRIM, 32'h0000_03FF);
        wr(`ADDR_OFFSET_TRIM, 32'h0000_0200);
        rdw(32'hFFFF_0520, rd, rs);
        chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
        // Single software conversions: single-ended with the pin shown,
        // then differential with the pin hidden
        for (int i = 0; i < 2; i++)
        begin
            comp <= (i == 1);
            n0 = act_cnt;
            p0 = pin_cnt;
            o0 = open_cnt;
            s0 = sw_cnt;
            wr(`ADDR_MAIN_CONTROL, i == 0 ? 32'h0000_00E3 : 32'h0000_00AB);
            for (int k = 0; k < 60 && irq !== 1'b1; k++) @(posedge clk);
            chk({31'h0, irq}, 32'h0000_0001);
            chk({31'h0, tied_gnd},
                i == 0 ? 32'h0000_0001 : 32'h0000_0000);
            chk(act_cnt - n0, 14);
            chk(pin_cnt - p0, i == 0 ? 14 : 0);
            chk(open_cnt - o0, 15);
            chk(sw_cnt - s0, 14);
            chk({31'h0, bal}, 32'h0000_0001);
            chk({20'h0, dac}, i == 0 ? 32'h0000_0000 : 32'h0000_0FFF);
            @(posedge clk);
            rchk(`ADDR_MAIN_CONTROL,
                 i == 0 ? 32'h0000_00E0 : 32'h0000_00A8);
            rchk(`ADDR_STATUS, 32'h0000_0001);
            wr(`ADDR_STATUS, 32'h0000_0000);
            wr(`ADDR_RESULT, 32'h0000_0123);
            rchk(`ADDR_STATUS, 32'h0000_0001);
            rchk(`ADDR_RESULT,
                 i == 0 ? 32'h0000_0000 : 32'h0000_0FFF);
            rchk(`ADDR_STATUS, 32'h0000_0000);
        end
        // Conversion requested by the start pin, result left unread
        wr(`ADDR_MAIN_CONTROL, 32'h0000_00A0);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int k = 0; k < 60 && irq !== 1'b1; k++) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        rchk(`ADDR_STATUS, 32'h0000_0001);
        wr(`ADDR_POS_SELECT, 32'h0000_0007);
        wr(`ADDR_GAIN_TRIM, 32'h0000_0155);
        wr(`ADDR_IF_RESET, 32'h0000_005A);
        defaults();
        end_of_test();
    end
endmodule // tb_sar_adc_interface
